// *** verilog/ldf_diag_top.v ***
// Purpose: ten-channel load diagnosis, filter and OVERCURRENT_OVERTEMP_FAULT latch-off
// Assumes: fault inputs from pins, synchronised here
// Notes: registers reached over Avalon-MM, one wait state
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
`include "ldf_map.vh"
module ldf_diag_top (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [9:0] chan_on_i,
  input wire [9:0] open_load_fault_i,
  input wire [9:0] short_to_ground_fault_i,
  input wire [9:0] overcurrent_overtemp_fault_i,
  output wire [9:0] chan_drive_o,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest
);
  localparam ST_IDLE = 1'b0;
  localparam ST_DONE = 1'b1;
  // Reset value of the settings word
  localparam [31:0] SET_RST = `LDF_SET_RESET;
  reg bus_state;
  reg next_bus_state;

  // Pin synchroniser stages
  reg [9:0] ol_m, ol_s, sg_m, sg_s, oc_m, oc_s, on_m, on_s;

  // Stored diagnosis, latch-off mask and host settings
  reg [19:0] channel_diag_field;
  reg [9:0] latched_off;
  reg [9:0] off_diag_enable_bit;
  reg [1:0] diag_blind_time_bits;
  reg [9:0] pend_valid;
  reg [19:0] pend_code;

  // Filter results and classified conditions
  wire [9:0] flt_done;
  wire [19:0] flt_code;
  wire [9:0] cond_valid;
  wire [19:0] cond_code;

  // Bus decode and next values
  wire acc;
  wire clr_a, clr_b;
  wire wr_busy;
  reg [9:0] next_latched_off;
  reg [19:0] next_field;
  reg [9:0] next_pend_valid;
  reg [19:0] next_pend_code;
  integer i;
  genvar g;

  // Filter limit: blind time only for the upper four channels
  function [`LDF_CNT_W-1:0] limit_for;
    input integer ch;
    input [1:0] dbt;
    reg [31:0] cycles;
    begin
      if (ch >= 6 && dbt[0] && dbt[1])
        cycles = `LDF_BT2_CYC;
      else if (ch >= 6 && dbt[0])
        cycles = `LDF_BT1_CYC;
      else
        cycles = `LDF_TD_CYC;
      limit_for = cycles[`LDF_CNT_W-1:0]; // Longest count still fits the timer
    end
  endfunction

  // Two-stage synchronisers on fault pins
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ol_m <= 10'h000;
      ol_s <= 10'h000;
      sg_m <= 10'h000;
      sg_s <= 10'h000;
      oc_m <= 10'h000;
      oc_s <= 10'h000;
    end else begin
      ol_m <= open_load_fault_i;
      ol_s <= ol_m;
      sg_m <= short_to_ground_fault_i;
      sg_s <= sg_m;
      oc_m <= overcurrent_overtemp_fault_i;
      oc_s <= oc_m;
    end
  end

  // On-command synchroniser; drive follows it two cycles late
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_m <= 10'h000;
      on_s <= 10'h000;
    end else begin
      on_m <= chan_on_i;
      on_s <= on_m;
    end
  end

  // Per-channel condition classification and filter
  generate
    for (g = 0; g < 10; g = g + 1) begin : g_ch
      wire off_ok = on_s[g] | off_diag_enable_bit[g];
      assign cond_valid[g] = oc_s[g] | (off_ok & (ol_s[g] | sg_s[g]));
      // Overcurrent wins over open or short when both are present
      assign cond_code[2*g+1:2*g] = oc_s[g] ? `LDF_CODE_OCT :
                                    (sg_s[g] ? `LDF_CODE_SCG : `LDF_CODE_OL);
      ldf_chan_filter u_flt (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .cond_valid_i(cond_valid[g]),
        .cond_code_i(cond_code[2*g+1:2*g]),
        .limit_i(limit_for(g, diag_blind_time_bits)),
        .done_o(flt_done[g]),
        .code_o(flt_code[2*g+1:2*g])
      );
    end
  endgenerate

  // Latched-off channels are masked from the drive
  assign chan_drive_o = on_s & ~latched_off;

  // Avalon slave: one wait state per access
  assign acc = avs_read | avs_write;
  assign avs_waitrequest = acc & (bus_state == ST_IDLE);
  assign wr_busy = avs_write & (bus_state == ST_DONE);
  assign clr_a = wr_busy & (avs_address == `LDF_OFF_CLEAR) & avs_writedata[`LDF_CLR_A_BIT];
  assign clr_b = wr_busy & (avs_address == `LDF_OFF_CLEAR) & avs_writedata[`LDF_CLR_B_BIT];

  // Diagnosis store, pending latch and clear handling
  always @* begin
    next_field = channel_diag_field;
    next_latched_off = latched_off;
    next_pend_valid = pend_valid;
    next_pend_code = pend_code;
    for (i = 0; i < 10; i = i + 1) begin
      if ((i < 5 && clr_a) || (i >= 5 && clr_b)) begin
        next_field[2*i +: 2] = `LDF_CODE_OK;
        next_latched_off[i] = 1'b0;
      end
      if (flt_done[i]) begin
        next_pend_valid[i] = 1'b1;
        next_pend_code[2*i +: 2] = flt_code[2*i +: 2];
      end
      // Hold result while any register write completes
      if (next_pend_valid[i] && !wr_busy) begin
        next_field[2*i +: 2] = next_pend_code[2*i +: 2];
        next_latched_off[i] = (next_pend_code[2*i +: 2] == `LDF_CODE_OCT);
        next_pend_valid[i] = 1'b0;
      end
    end
  end

  // Diagnosis state; reset leaves every channel at no fault
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_diag_field <= 20'hfffff;
      latched_off <= 10'h000;
      pend_valid <= 10'h000;
      pend_code <= 20'hfffff;
    end else begin
      channel_diag_field <= next_field;
      latched_off <= next_latched_off;
      pend_valid <= next_pend_valid;
      pend_code <= next_pend_code;
    end
  end

  // Next bus state; every access waits exactly one cycle
  always @* begin
    case (bus_state)
      ST_IDLE: next_bus_state = acc ? ST_DONE : ST_IDLE;
      ST_DONE: next_bus_state = ST_IDLE;
      default: next_bus_state = ST_IDLE;
    endcase
  end

  // Bus state register
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state <= ST_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Settings; a write lands only in its completing cycle
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_diag_enable_bit <= SET_RST[9:0];
      diag_blind_time_bits <= SET_RST[11:10];
    end else if (wr_busy && avs_address == `LDF_OFF_SETTINGS) begin
      off_diag_enable_bit <= avs_writedata[9:0];
      diag_blind_time_bits <= {avs_writedata[`LDF_SET_DBT2_BIT], avs_writedata[`LDF_SET_DBT1_BIT]};
    end
  end

  // Read data taken in the wait cycle, so it stands when wait drops
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && bus_state == ST_IDLE) begin
      case (avs_address)
        `LDF_OFF_DIAG_A: avs_readdata <= {22'h000000, channel_diag_field[9:0]};
        `LDF_OFF_DIAG_B: avs_readdata <= {22'h000000, channel_diag_field[19:10]};
        `LDF_OFF_SETTINGS: avs_readdata <= {20'h00000, diag_blind_time_bits, off_diag_enable_bit};
        default: avs_readdata <= {22'h000000, latched_off};
      endcase
    end
  end
endmodule

// *** verilog/ldf_map.vh ***
// Purpose: constants of the load diagnosis filter
// Assumes: 10 MHz mclk_i, 32-bit Avalon-MM register bus
// Notes: byte offsets, field codes and filter counts
`ifndef LDF_MAP_VH
`define LDF_MAP_VH
`define LDF_NCH 10
`define LDF_CODE_SCG 2'b00
`define LDF_CODE_OL 2'b01
`define LDF_CODE_OCT 2'b10
`define LDF_CODE_OK 2'b11
`define LDF_CLK_HZ 10000000
`define LDF_TD_US 220
`define LDF_TD_CYC ((`LDF_TD_US * (`LDF_CLK_HZ / 1000000)))
`define LDF_BT1_US 2500
`define LDF_BT1_CYC ((`LDF_BT1_US * (`LDF_CLK_HZ / 1000000)))
`define LDF_BT2_US 5000
`define LDF_BT2_CYC ((`LDF_BT2_US * (`LDF_CLK_HZ / 1000000)))
`define LDF_CNT_W 16
`define LDF_OFF_DIAG_A 4'h0
`define LDF_OFF_DIAG_B 4'h4
`define LDF_OFF_SETTINGS 4'h8
`define LDF_OFF_CLEAR 4'hc
`define LDF_SET_DCC_LSB 0
`define LDF_SET_DBT1_BIT 10
`define LDF_SET_DBT2_BIT 11
`define LDF_SET_RESET 32'h000003ff
`define LDF_CLR_A_BIT 0
`define LDF_CLR_B_BIT 1
`endif

// *** verilog/ldf_chan_filter.v ***
// Purpose: one channel's diagnosis filter timer
// Assumes: condition inputs already synchronised
// Notes: reports a filtered code each time a condition has held for the limit
`timescale 1ns/1ns
`include "ldf_map.vh"
module ldf_chan_filter (
  input wire mclk_i,
  input wire rst_n_i,
  input wire cond_valid_i,
  input wire [1:0] cond_code_i,
  input wire [`LDF_CNT_W-1:0] limit_i,
  output reg done_o,
  output reg [1:0] code_o
);
  reg [`LDF_CNT_W-1:0] cnt;
  reg running;
  wire kind_flip;

  // Overcurrent versus open/short change restarts, so no class rides another's delay
  assign kind_flip = running & ((cond_code_i == `LDF_CODE_OCT) != (code_o == `LDF_CODE_OCT));

  // Timer runs while any fault is present; OL/SHORT_TO_GROUND_FAULT swaps keep the count
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 16'h0000;
      running <= 1'b0;
      done_o <= 1'b0;
      code_o <= `LDF_CODE_OK;
    end else begin
      done_o <= 1'b0;
      if (!cond_valid_i) begin
        cnt <= 16'h0000;
        running <= 1'b0;
      end else if (kind_flip) begin
        cnt <= 16'h0001;
        code_o <= cond_code_i;
      end else if (!running || cnt + 16'h0001 < limit_i) begin
        running <= 1'b1;
        cnt <= cnt + 16'h0001;
        code_o <= cond_code_i;
      end else begin
        // Expiry: store latest code, then restart for a fresh report
        done_o <= 1'b1;
        code_o <= cond_code_i;
        cnt <= 16'h0000;
        running <= 1'b0;
      end
    end
  end
endmodule

// *** tb/ldf_diag_checker_assertions.sv ***
// Purpose: port-level checks of the load diagnosis filter
// Assumes: one clock, async active-low reset
// Notes: timed checks watch channel 1 only
`timescale 1ns/1ns
module ldf_diag_checker (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [9:0] chan_on_i,
  input wire [9:0] open_load_fault_i,
  input wire [9:0] short_to_ground_fault_i,
  input wire [9:0] overcurrent_overtemp_fault_i,
  input wire [9:0] chan_drive_o,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  reg [15:0] oct_cnt;
  // Cycles of steady overcurrent on channel 1 while commanded on
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) oct_cnt <= 16'h0000;
    else if (!(overcurrent_overtemp_fault_i[0] && chan_on_i[0])) oct_cnt <= 16'h0000;
    else if (oct_cnt != 16'hffff) oct_cnt <= oct_cnt + 16'h0001;
  end
  // Bus steps and a quiet, switched-on channel 1
  sequence req_rise; $rose(avs_read | avs_write); endsequence
  sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
  // Five cycles cover the pin sync, the filter flop and one held-result cycle
  sequence ch1_quiet; (chan_on_i[0] && !open_load_fault_i[0] && !short_to_ground_fault_i[0]) [*5]; endsequence
  wait_state_a: assert property (req_rise |-> one_wait)
    else $error("bus answer not after one wait");
  one_wait_a: assert property (avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  wait_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("wait raised with no request");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  drive_gate_a: assert property ((chan_drive_o & ~$past(chan_on_i, 2)) == 10'h000)
    else $error("drive without on command");
  oct_off_a: assert property (oct_cnt == 16'd2210 |-> !chan_drive_o[0])
    else $error("overcurrent left channel on");
  drop_late_a: assert property ($fell(chan_drive_o[0]) && $past(chan_on_i[0], 2) |-> oct_cnt > 16'd2100)
    else $error("channel dropped before filter delay");
  latch_hold_a: assert property (ch1_quiet ##0 (!chan_drive_o[0] && !avs_write) |=> !chan_drive_o[0])
    else $error("latched channel released");
endmodule

// *** tb/ldf_load_model.sv ***
// Purpose: load-side fault source for the diagnosis bench
// Assumes: two-bit kind per channel, 11 is a healthy load
// Notes: levels only; analog thresholds are not modelled
`timescale 1ns/1ns
module ldf_load_model (
  input wire [19:0] kind_i,
  output reg [9:0] ol_o,
  output reg [9:0] scg_o,
  output reg [9:0] oct_o
);
  integer k;
  // Each channel's kind uses the diagnosis codes, so one table serves both
  always @* begin
    for (k = 0; k < 10; k = k + 1) begin
      ol_o[k] = kind_i[2*k+:2] == 2'b01;
      scg_o[k] = kind_i[2*k+:2] == 2'b00;
      oct_o[k] = kind_i[2*k+:2] == 2'b10;
    end
  end
endmodule

// *** tb/tb_load_diagnosis_filter.sv ***
// Purpose: self-checking bench of the load diagnosis filter
// Assumes: 10 MHz clock, host-side steps driven from here
// Notes: the 5 ms blind setting takes most of the run time
`timescale 1ns/1ns
`include "ldf_map.vh"
module tb_load_diagnosis_filter;
  reg mclk_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg [9:0] chan_on = 10'h000;
  reg [19:0] kind = 20'hfffff;
  reg [3:0] addr = 4'h0;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdata = 32'h00000000;
  wire [9:0] ol, short_to_ground_fault, overcurrent_overtemp_fault, drive;
  wire [31:0] rdata;
  wire wait_r;
  integer failures = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  ldf_load_model i_load (.kind_i(kind), .ol_o(ol), .scg_o(short_to_ground_fault), .oct_o(overcurrent_overtemp_fault));
  ldf_diag_top i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .chan_on_i(chan_on), .open_load_fault_i(ol),
    .short_to_ground_fault_i(short_to_ground_fault), .overcurrent_overtemp_fault_i(overcurrent_overtemp_fault), .chan_drive_o(drive),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(wait_r));
  // Free-running clock
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task cmp32(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task bus(input w, input [3:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge mclk_i);
      addr <= a;
      wdata <= d;
      rd <= !w;
      wr <= w;
      @(posedge mclk_i);
      while (wait_r !== 1'b0) @(posedge mclk_i);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask
  task rd_chk(input [3:0] a, input [31:0] e);
    reg [31:0] q;
    begin
      bus(1'b0, a, 32'h00000000, q);
      cmp32(q, e);
    end
  endtask
  task wr_reg(input [3:0] a, input [31:0] d);
    reg [31:0] q;
    begin
      bus(1'b1, a, d, q);
    end
  endtask
  // Main sequence; fixed waits follow the filter counts
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd_chk(4'h0, 32'h000003ff);
    rd_chk(4'h4, 32'h000003ff);
    rd_chk(4'h8, 32'h000003ff);
    rd_chk(4'hc, 32'h00000000);
    kind <= 20'hffff5;
    repeat (1000) @(posedge mclk_i);
    kind <= 20'hffff1;
    repeat (500) @(posedge mclk_i);
    rd_chk(4'h0, 32'h000003ff);
    repeat (`LDF_TD_CYC - 1480) @(posedge mclk_i);
    rd_chk(4'h0, 32'h000003f1);
    kind <= 20'hffffe;
    chan_on <= 10'h001;
    repeat (`LDF_TD_CYC + 20) @(posedge mclk_i);
    cmp32({22'h000000, drive}, 32'h00000000);
    rd_chk(4'h0, 32'h000003f2);
    rd_chk(4'hc, 32'h00000001);
    kind <= 20'hfffff;
    repeat (100) @(posedge mclk_i);
    cmp32({22'h000000, drive}, 32'h00000000);
    wr_reg(4'h8, 32'h000003fe);
    wr_reg(4'hc, 32'h00000001);
    repeat (3) @(posedge mclk_i);
    cmp32({22'h000000, drive}, 32'h00000001);
    rd_chk(4'h0, 32'h000003ff);
    chan_on <= 10'h000;
    kind <= 20'hffff5;
    repeat (`LDF_TD_CYC + 20) @(posedge mclk_i);
    rd_chk(4'h0, 32'h000003f7);
    wr_reg(4'h8, 32'h000007ff);
    kind <= 20'hfdffd;
    repeat (`LDF_TD_CYC + 20) @(posedge mclk_i);
    rd_chk(4'h0, 32'h000003f5);
    rd_chk(4'h4, 32'h000003ff);
    repeat (`LDF_BT1_CYC - `LDF_TD_CYC) @(posedge mclk_i);
    rd_chk(4'h4, 32'h000003f7);
    wr_reg(4'h8, 32'h00000fff);
    kind <= 20'hf7fff;
    repeat (`LDF_BT1_CYC + 20) @(posedge mclk_i);
    rd_chk(4'h4, 32'h000003f7);
    repeat (`LDF_BT2_CYC - `LDF_BT1_CYC) @(posedge mclk_i);
    rd_chk(4'h4, 32'h000003d7);
    // Mid-run reset brings settings and fields back
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd_chk(4'h8, 32'h000003ff);
    rd_chk(4'h4, 32'h000003ff);
    print_verdict;
  end
  // Cut a hung run short
  always @(posedge mclk_i) begin
    cyc = cyc + 1;
    if (cyc == 95000) begin
      failures = failures + 1;
      print_verdict;
    end
  end
endmodule
bind ldf_diag_top ldf_diag_checker i_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .chan_on_i(chan_on_i),
  .open_load_fault_i(open_load_fault_i), .short_to_ground_fault_i(short_to_ground_fault_i),
  .overcurrent_overtemp_fault_i(overcurrent_overtemp_fault_i), .chan_drive_o(chan_drive_o),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
